// *** hdl/isp_slave.sv ***
// Register slave port: two-wire slave giving a master access to 16-bit registers.
// Assumes the register bank outside answers rd_data for reg_ptr in the same cycle.
`timescale 1ns/10ps
`default_nettype none

module isp_slave #(
	parameter logic [6:0] SLAVE_ADDR = isp_pkg::DEF_SLAVE_ADDR
)(
	input  wire logic        clock,
	input  wire logic        rst,
	isp_if.slave             bus,
	output logic      [7:0]  reg_ptr,
	output logic      [15:0] wr_data,
	output logic             wr_stb,
	input  wire logic [15:0] rd_data
);
	import isp_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0] scl_q;
	logic [2:0] sda_q;
	logic [2:0] next_scl_q;
	logic [2:0] next_sda_q;

	always_comb
	begin
		next_scl_q = {scl_q[1:0], bus.scl};
		next_sda_q = {sda_q[1:0], bus.sda};
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			scl_q <= 3'h7;
			sda_q <= 3'h7;
		end
		else
		begin
			scl_q <= next_scl_q;
			sda_q <= next_sda_q;
		end
	end

	// Stage 0 feeds stage 1 only; edges compare stages 1 and 2
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic sda_in;

	assign sda_in    = sda_q[1];
	assign scl_rise  = scl_q[1] & ~scl_q[2];
	assign scl_fall  = ~scl_q[1] & scl_q[2];
	assign bus_start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
	assign bus_stop  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

	// ****************************************************************
	// Protocol engine
	// ****************************************************************
	isp_sstate_t state;
	isp_sstate_t next_state;
	isp_wphase_t wph;
	isp_wphase_t next_wph;
	logic [3:0]  cnt;
	logic [3:0]  next_cnt;
	logic [7:0]  rx;
	logic [7:0]  next_rx;
	logic [7:0]  tx;
	logic [7:0]  next_tx;
	logic [7:0]  lo_byte;
	logic [7:0]  next_lo_byte;
	logic [7:0]  hi_byte;
	logic [7:0]  next_hi_byte;
	logic [7:0]  next_reg_ptr;
	logic [15:0] next_wr_data;
	logic        next_wr_stb;
	logic        oe;
	logic        next_oe;
	logic        dir;
	logic        next_dir;
	logic        lo_pending;
	logic        next_lo_pending;
	logic        nack;
	logic        next_nack;

	always_comb
	begin
		next_state      = state;
		next_wph        = wph;
		next_cnt        = cnt;
		next_rx         = rx;
		next_tx         = tx;
		next_lo_byte    = lo_byte;
		next_hi_byte    = hi_byte;
		next_reg_ptr    = reg_ptr;
		next_wr_data    = wr_data;
		next_wr_stb     = 1'b0;
		next_oe         = oe;
		next_dir        = dir;
		next_lo_pending = lo_pending;
		next_nack       = nack;
		if (bus_stop)
		begin
			next_state = S_IDLE;
			next_oe    = 1'b0;
		end
		else if (bus_start)
		begin
			// Repeated START also lands here; the pointer survives it
			next_state = S_ADDR;
			next_cnt   = CNT_ZERO;
			next_oe    = 1'b0;
			next_wph   = WP_PTR;
		end
		else
		begin
			case (state)
				S_ADDR, S_WR_BYTE:
				begin
					if (scl_rise)
					begin
						next_rx  = {rx[6:0], sda_in};
						next_cnt = cnt + 4'h1;
					end
					else if (scl_fall && cnt == CNT_DATA_DONE)
					begin
						if (state == S_ADDR)
						begin
							if (rx[7:1] == SLAVE_ADDR)
							begin
								next_state = S_ADDR_ACK;
								next_oe    = 1'b1;
								next_dir   = rx[0];
							end
							else
							begin
								next_state = S_IDLE;
							end
						end
						else
						begin
							next_state = S_WR_ACK;
							next_oe    = 1'b1;
							case (wph)
								WP_PTR:
								begin
									next_reg_ptr = rx;
									next_wph     = WP_HI;
								end
								WP_HI:
								begin
									next_hi_byte = rx;
									next_wph     = WP_LO;
								end
								WP_LO:
								begin
									next_wr_data = {hi_byte, rx};
									next_wr_stb  = 1'b1;
									next_wph     = WP_PTR;
								end
								default:
								begin
									next_wph = WP_PTR;
								end
							endcase
						end
					end
				end
				S_ADDR_ACK, S_WR_ACK:
				begin
					if (scl_rise)
					begin
						next_cnt = CNT_ACK_DONE;
					end
					else if (scl_fall && cnt == CNT_ACK_DONE)
					begin
						next_cnt = CNT_ZERO;
						if (state == S_ADDR_ACK && dir == RW_READ)
						begin
							next_state      = S_RD_BYTE;
							next_tx         = rd_data[15:8];
							next_lo_byte    = rd_data[7:0];
							next_lo_pending = 1'b1;
							next_oe         = ~rd_data[15];
						end
						else
						begin
							next_state = S_WR_BYTE;
							next_oe    = 1'b0;
						end
					end
				end
				S_RD_BYTE:
				begin
					if (scl_rise)
					begin
						next_cnt = cnt + 4'h1;
					end
					else if (scl_fall)
					begin
						// Data moves only after SCL has fallen
						if (cnt == CNT_DATA_DONE)
						begin
							next_state = S_RD_ACK;
							next_oe    = 1'b0;
						end
						else
						begin
							next_tx = {tx[6:0], 1'b0};
							next_oe = ~tx[6];
						end
					end
				end
				S_RD_ACK:
				begin
					if (scl_rise)
					begin
						next_nack = sda_in;
						next_cnt  = CNT_ACK_DONE;
					end
					else if (scl_fall && cnt == CNT_ACK_DONE)
					begin
						next_cnt = CNT_ZERO;
						if (nack)
						begin
							next_state = S_IDLE;
						end
						else if (lo_pending)
						begin
							next_state      = S_RD_BYTE;
							next_tx         = lo_byte;
							next_oe         = ~lo_byte[7];
							next_lo_pending = 1'b0;
						end
						else
						begin
							// Same register again: the pointer does not advance
							next_state      = S_RD_BYTE;
							next_tx         = rd_data[15:8];
							next_lo_byte    = rd_data[7:0];
							next_oe         = ~rd_data[15];
							next_lo_pending = 1'b1;
						end
					end
				end
				default:
				begin
					next_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state      <= S_IDLE;
			wph        <= WP_PTR;
			cnt        <= CNT_ZERO;
			rx         <= 8'h00;
			tx         <= 8'h00;
			lo_byte    <= 8'h00;
			hi_byte    <= 8'h00;
			reg_ptr    <= PTR_RESET;
			wr_data    <= WORD_RESET;
			wr_stb     <= 1'b0;
			oe         <= 1'b0;
			dir        <= RW_WRITE;
			lo_pending <= 1'b0;
			nack       <= 1'b0;
		end
		else
		begin
			state      <= next_state;
			wph        <= next_wph;
			cnt        <= next_cnt;
			rx         <= next_rx;
			tx         <= next_tx;
			lo_byte    <= next_lo_byte;
			hi_byte    <= next_hi_byte;
			reg_ptr    <= next_reg_ptr;
			wr_data    <= next_wr_data;
			wr_stb     <= next_wr_stb;
			oe         <= next_oe;
			dir        <= next_dir;
			lo_pending <= next_lo_pending;
			nack       <= next_nack;
		end
	end

	// Open drain: only ever pulls low, never drives SCL
	assign bus.s_sda_o  = 1'b0;
	assign bus.s_sda_oe = oe;

endmodule

`default_nettype wire

// *** include/isp_pkg.sv ***
// Shared constants and state types for the two-wire register slave port.
// Assumes a 40 MHz system clock on both ends; no clock crosses between them.
`default_nettype none

package isp_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 25;
	// Slow enough that both ends see each other through their synchronisers
	localparam int SCL_PERIOD_NS = 400;
	localparam int QTR_CYCLES    = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

	// ****************************************************************
	// Byte framing
	// ****************************************************************
	localparam logic [3:0] CNT_ZERO      = 4'h0;
	localparam logic [3:0] CNT_DATA_DONE = 4'h8;
	localparam logic [3:0] CNT_ACK_DONE  = 4'h9;
	localparam logic       RW_WRITE      = 1'b0;
	localparam logic       RW_READ       = 1'b1;
	// Arbitrary default bus address
	localparam logic [6:0] DEF_SLAVE_ADDR = 7'h20;
	localparam logic [7:0] PTR_RESET      = 8'h00;
	localparam logic [15:0] WORD_RESET    = 16'h0000;

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef enum logic [2:0]
	{
		S_IDLE     = 3'h0,
		S_ADDR     = 3'h1,
		S_ADDR_ACK = 3'h3,
		S_WR_BYTE  = 3'h2,
		S_WR_ACK   = 3'h6,
		S_RD_BYTE  = 3'h7,
		S_RD_ACK   = 3'h5
	} isp_sstate_t;

	typedef enum logic [1:0]
	{
		WP_PTR = 2'h0,
		WP_HI  = 2'h1,
		WP_LO  = 2'h3
	} isp_wphase_t;

	typedef enum logic [1:0]
	{
		M_IDLE  = 2'h0,
		M_START = 2'h1,
		M_BYTE  = 2'h3,
		M_STOP  = 2'h2
	} isp_mstate_t;

endpackage

`default_nettype wire

// *** include/isp_if.sv ***
// Two-wire bus between the register slave port and its bus master.
// Open-drain wires with pull-ups are resolved here from the drive enables.
`timescale 1ns/10ps
`default_nettype none

interface isp_if;
	logic m_scl_o;
	logic m_scl_oe;
	logic m_sda_o;
	logic m_sda_oe;
	logic s_sda_o;
	logic s_sda_oe;
	logic scl;
	logic sda;

	// Pull-up: a released wire reads high
	assign scl = m_scl_oe ? m_scl_o : 1'b1;
	assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (s_sda_oe ? s_sda_o : 1'b1);

	modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
	modport slave (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

`default_nettype wire

// *** hdl/isp_master.sv ***
// Bus master end: runs write and read commands against the register slave port.
// Assumes a single master on the bus; SCL is made here by dividing the clock.
`timescale 1ns/10ps
`default_nettype none

module isp_master #(
	parameter logic [6:0] SLAVE_ADDR = isp_pkg::DEF_SLAVE_ADDR,
	parameter int         QTR        = isp_pkg::QTR_CYCLES
)(
	input  wire logic        clock,
	input  wire logic        rst,
	isp_if.master            bus,
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic        cmd_read,
	input  wire logic [7:0]  cmd_ptr,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic [7:0]  cmd_words,
	output logic      [15:0] rd_word,
	output logic             rd_valid,
	output logic             done,
	output logic             nack_err
);
	import isp_pkg::*;

	// ****************************************************************
	// SDA synchroniser and quarter-period timer
	// ****************************************************************
	logic [1:0] sda_q;
	logic [7:0] qcnt;
	logic       tick;
	logic       sda_in;

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			sda_q <= 2'h3;
		else
			sda_q <= {sda_q[0], bus.sda};
	end

	assign sda_in = sda_q[1];
	assign tick   = qcnt == 8'(QTR - 1);

	// Drive enable for SDA: high means pull the wire low
	function automatic logic sda_drive(input logic rx, input logic ack_slot, input logic msb, input logic nak);
		if (ack_slot)
			return rx & ~nak;
		return ~rx & ~msb;
	endfunction

	// ****************************************************************
	// Transfer sequencer
	// ****************************************************************
	isp_mstate_t state, next_state;
	logic [7:0]  next_qcnt;
	logic [1:0]  q, next_q, bidx, next_bidx;
	logic [3:0]  bitc, next_bitc;
	logic [7:0]  sh, next_sh, hi, next_hi, words_left, next_words_left, ptr, next_ptr;
	logic [15:0] wdata, next_wdata, next_rd_word;
	logic        rx_mode, next_rx_mode, reading, next_reading, rd_hi, next_rd_hi;
	logic        nack_out, next_nack_out, is_read, next_is_read;
	logic        scl_oe, next_scl_oe, sda_oe, next_sda_oe;
	logic        next_rd_valid, next_done, next_nack_err;

	always_comb
	begin
		{next_state, next_q, next_bidx, next_bitc} = {state, q, bidx, bitc};
		{next_sh, next_hi, next_words_left, next_ptr, next_wdata} = {sh, hi, words_left, ptr, wdata};
		{next_rx_mode, next_reading, next_rd_hi, next_nack_out} = {rx_mode, reading, rd_hi, nack_out};
		{next_is_read, next_scl_oe, next_sda_oe, next_nack_err} = {is_read, scl_oe, sda_oe, nack_err};
		next_rd_word  = rd_word;
		next_rd_valid = 1'b0;
		next_done     = 1'b0;
		next_qcnt     = tick ? 8'h00 : qcnt + 8'h01;
		if (tick)
			next_q = q + 2'h1;
		case (state)
			M_IDLE:
			begin
				next_qcnt = 8'h00;
				next_q    = 2'h0;
				if (cmd_valid)
				begin
					next_state      = M_START;
					next_is_read    = cmd_read;
					next_ptr        = cmd_ptr;
					next_wdata      = cmd_wdata;
					next_words_left = (cmd_words == 8'h00) ? 8'h01 : cmd_words;
					next_bidx       = 2'h0;
					next_reading    = 1'b0;
					next_nack_err   = 1'b0;
					next_scl_oe     = 1'b1;
					next_sda_oe     = 1'b0;
				end
			end
			M_START:
			begin
				if (tick)
				begin
					case (q)
						2'h0: next_scl_oe = 1'b0;
						2'h1: next_sda_oe = 1'b1;
						2'h2: next_scl_oe = 1'b1;
						default:
						begin
							// A repeated START after the pointer byte turns the bus round
							next_bidx    = (bidx == 2'h1) ? 2'h2 : 2'h0;
							next_sh      = {SLAVE_ADDR, (bidx == 2'h1) ? RW_READ : RW_WRITE};
							next_state   = M_BYTE;
							next_bitc    = CNT_ZERO;
							next_rx_mode = 1'b0;
							next_sda_oe  = sda_drive(1'b0, 1'b0, next_sh[7], 1'b0);
						end
					endcase
				end
			end
			M_BYTE:
			begin
				if (tick)
				begin
					case (q)
						2'h0: next_scl_oe = 1'b0;
						2'h1:
						begin
							if (bitc == CNT_DATA_DONE)
							begin
								if (!rx_mode && sda_in)
									next_nack_err = 1'b1;
							end
							else if (rx_mode)
								next_sh = {sh[6:0], sda_in};
						end
						2'h2: next_scl_oe = 1'b1;
						default:
						begin
							if (bitc != CNT_DATA_DONE)
							begin
								next_bitc = bitc + 4'h1;
								if (!rx_mode)
									next_sh = {sh[6:0], 1'b0};
								next_sda_oe = sda_drive(rx_mode, next_bitc == CNT_DATA_DONE, next_sh[7], nack_out);
							end
							else
							begin
								next_bitc    = CNT_ZERO;
								next_sda_oe  = 1'b0;
								next_rx_mode = 1'b1;
								if (nack_err)
								begin
									next_state  = M_STOP;
									next_sda_oe = 1'b1;
								end
								else if (!reading)
								begin
									next_rx_mode = 1'b0;
									case (bidx)
										2'h0:
										begin
											next_bidx   = 2'h1;
											next_sh     = ptr;
											next_sda_oe = sda_drive(1'b0, 1'b0, ptr[7], 1'b0);
										end
										2'h1:
										begin
											if (is_read)
												next_state = M_START;
											else
											begin
												next_bidx   = 2'h2;
												next_sh     = wdata[15:8];
												next_sda_oe = sda_drive(1'b0, 1'b0, wdata[15], 1'b0);
											end
										end
										2'h2:
										begin
											if (is_read)
											begin
												next_reading  = 1'b1;
												next_rd_hi    = 1'b1;
												next_nack_out = 1'b0;
												next_rx_mode  = 1'b1;
											end
											else
											begin
												next_bidx   = 2'h3;
												next_sh     = wdata[7:0];
												next_sda_oe = sda_drive(1'b0, 1'b0, wdata[7], 1'b0);
											end
										end
										default:
										begin
											next_state  = M_STOP;
											next_sda_oe = 1'b1;
										end
									endcase
								end
								else if (rd_hi)
								begin
									next_hi       = sh;
									next_rd_hi    = 1'b0;
									next_nack_out = words_left == 8'h01;
								end
								else
								begin
									next_rd_word  = {hi, sh};
									next_rd_valid = 1'b1;
									if (words_left == 8'h01)
									begin
										next_state  = M_STOP;
										next_sda_oe = 1'b1;
									end
									else
									begin
										next_words_left = words_left - 8'h01;
										next_rd_hi      = 1'b1;
									end
								end
							end
						end
					endcase
				end
			end
			M_STOP:
			begin
				if (tick)
				begin
					case (q)
						2'h0: next_scl_oe = 1'b0;
						2'h1: next_sda_oe = 1'b0;
						2'h2: next_sda_oe = 1'b0;
						default:
						begin
							next_done  = 1'b1;
							next_state = M_IDLE;
						end
					endcase
				end
			end
			default: next_state = M_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			{state, q, bidx, bitc, qcnt} <= {M_IDLE, 2'h0, 2'h0, CNT_ZERO, 8'h00};
			{sh, hi, words_left, ptr, wdata, rd_word} <= {8'h00, 8'h00, 8'h01, PTR_RESET, WORD_RESET, WORD_RESET};
			{rx_mode, reading, rd_hi, nack_out, is_read} <= 5'h00;
			{scl_oe, sda_oe, rd_valid, done, nack_err} <= 5'h00;
		end
		else
		begin
			{state, q, bidx, bitc, qcnt} <= {next_state, next_q, next_bidx, next_bitc, next_qcnt};
			{sh, hi, words_left, ptr} <= {next_sh, next_hi, next_words_left, next_ptr};
			{wdata, rd_word} <= {next_wdata, next_rd_word};
			{rx_mode, reading, rd_hi, nack_out, is_read} <= {next_rx_mode, next_reading, next_rd_hi, next_nack_out, next_is_read};
			{scl_oe, sda_oe, rd_valid, done, nack_err} <= {next_scl_oe, next_sda_oe, next_rd_valid, next_done, next_nack_err};
		end
	end

	assign cmd_ready    = state == M_IDLE;
	assign bus.m_scl_o  = 1'b0;
	assign bus.m_scl_oe = scl_oe;
	assign bus.m_sda_o  = 1'b0;
	assign bus.m_sda_oe = sda_oe;

endmodule

`default_nettype wire

// *** sim/isp_monitor.sv ***
// Checker for the two-wire bus between the master and slave ends.
// Assumes the resolved wires and drive enables of one bus, sampled by the system clock.
`timescale 1ns/10ps
`default_nettype none

module isp_monitor (
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic s_sda_oe
);
	logic [3:0] bitc;
	logic [3:0] next_bitc;
	logic [1:0] bytec;
	logic [1:0] next_bytec;
	logic       rw_q;
	logic       next_rw_q;
	logic       scl_q;
	logic       sda_q;

	// ****************************************************************
	// Bit and byte position since the last START
	// ****************************************************************
	always_comb
	begin
		next_bitc = bitc;
		next_bytec = bytec;
		next_rw_q = rw_q;
		if (scl && scl_q && sda_q && !sda)
		begin
			next_bitc = 4'h0;
			next_bytec = 2'h0;
		end
		else if (scl && !scl_q)
		begin
			next_bitc = (bitc == 4'h8) ? 4'h0 : bitc + 4'h1;
			// Saturates at 3: the first three bytes and the rest are told apart
			if (bitc == 4'h8 && bytec != 2'h3)
				next_bytec = bytec + 2'h1;
			// Direction comes from the address byte only; data bytes must not overwrite it
			if (bitc == 4'h7 && bytec == 2'h0)
				next_rw_q = sda;
		end
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			bitc <= 4'h0;
			bytec <= 2'h0;
			rw_q <= 1'b0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			bitc <= next_bitc;
			bytec <= next_bytec;
			rw_q <= next_rw_q;
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence ack_begin;
		$rose(s_sda_oe);
	endsequence
	sequence start_cond;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence stop_cond;
		scl && $past(scl) && $rose(sda);
	endsequence

	ack_ninth_a: assert property (ack_begin |-> (bytec != 2'h0) || (bitc == 4'h8))
		else $error("address acknowledge outside ninth bit");
	drive_low_a: assert property (ack_begin |-> !scl)
		else $error("slave drove data while clock high");
	// Open drain: one cycle of overlap as the master lets go is harmless, after that only one side drives
	slave_yield_a: assert property (s_sda_oe && $past(s_sda_oe) |-> !m_sda_oe)
		else $error("slave drove data while master drives");
	hold_eight_a: assert property (ack_begin |-> s_sda_oe [*8])
		else $error("slave drive too short");
	ack_release_a: assert property ($fell(scl) && bitc == 4'h0 && bytec != 2'h0 && !rw_q |-> ##[1:6] !s_sda_oe)
		else $error("write acknowledge not released");
	stop_release_a: assert property (stop_cond |-> ##[0:4] !s_sda_oe)
		else $error("slave holds data after stop");
	no_start_a: assert property (start_cond |-> m_sda_oe && !s_sda_oe && m_scl_oe == 1'b0)
		else $error("start not made by master");
	high_stable_a: assert property (scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe))
		else $error("data changed by slave while clock high");
endmodule

`default_nettype wire

// *** sim/tb_i2c_register_slave_port.sv ***
// Bench: master and slave ends on one bus, a second pair with a mismatched address.
// Assumes the design package and interface are compiled first.
`timescale 1ns/10ps
`default_nettype none

module tb_i2c_register_slave_port;
	import isp_pkg::*;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        vld = 1'b0;
	logic        vld_b = 1'b0;
	logic        rd = 1'b0;
	logic [7:0]  ptr = 8'h00;
	logic [7:0]  words = 8'h00;
	logic [15:0] wdat = 16'h0000;
	logic        cmd_ready, rd_valid, done, nack_err, wr_stb;
	logic        rdy_b, done_b, nack_b, stb_b;
	logic        b_seen = 1'b0;
	logic        cut = 1'b0;
	logic [7:0]  reg_ptr;
	logic [15:0] wr_data, rd_word, rd_data;
	logic [15:0] bank [256];
	logic [15:0] bm [256];
	logic [23:0] wq [$];
	logic [15:0] rq [$];
	logic [7:0]  pa [4];
	int          mismatches = 0;
	int          checked = 0;
	int          i;

	isp_if bus_a ();
	isp_if bus_b ();
	assign rd_data = bank[reg_ptr];

	isp_slave u_isp_slave (.clock(clock), .rst(rst), .bus(bus_a), .reg_ptr(reg_ptr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_data(rd_data));
	// The master alone can be reset to cut a frame short in mid byte
	isp_master u_isp_master (.clock(clock), .rst(rst | cut), .bus(bus_a), .cmd_valid(vld), .cmd_ready(cmd_ready),
		.cmd_read(rd), .cmd_ptr(ptr), .cmd_wdata(wdat), .cmd_words(words), .rd_word(rd_word),
		.rd_valid(rd_valid), .done(done), .nack_err(nack_err));
	// Second pair: master addresses a device that is not there
	isp_slave u_isp_slave_b (.clock(clock), .rst(rst), .bus(bus_b), .reg_ptr(), .wr_data(),
		.wr_stb(stb_b), .rd_data(16'h0000));
	isp_master #(.SLAVE_ADDR(DEF_SLAVE_ADDR ^ 7'h01)) u_isp_master_b (.clock(clock), .rst(rst), .bus(bus_b),
		.cmd_valid(vld_b), .cmd_ready(rdy_b), .cmd_read(rd), .cmd_ptr(ptr), .cmd_wdata(wdat),
		.cmd_words(words), .rd_word(), .rd_valid(), .done(done_b), .nack_err(nack_b));
	isp_monitor u_isp_monitor (.clock(clock), .rst(rst), .scl(bus_a.scl), .sda(bus_a.sda),
		.m_scl_oe(bus_a.m_scl_oe), .m_sda_oe(bus_a.m_sda_oe), .s_sda_oe(bus_a.s_sda_oe));

	initial
	begin
		forever #12.5 clock = ~clock;
	end

	// ****************************************************************
	// Checks and commands
	// ****************************************************************
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Entered and left just after a rising edge; notes expectations on take
	task automatic cmd(input logic r, input logic [7:0] p, input logic [15:0] d, input logic [7:0] n);
		int k;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 100)
		begin
			@(posedge clock);
			#1 k++;
		end
		chk(k < 100, "master never ready");
		rd = r;
		ptr = p;
		wdat = d;
		words = n;
		vld = 1'b1;
		@(posedge clock);
		#1 vld = 1'b0;
		if (!r)
		begin
			wq.push_back({p, d});
			bm[p] = d;
		end
		else
			for (k = 0; k < ((n == 8'h00) ? 1 : n); k++)
				rq.push_back(bm[p]);
		k = 0;
		while (done !== 1'b1 && k < 4000)
		begin
			@(posedge clock);
			#1 k++;
		end
		chk(k < 4000, "command did not finish");
		chk(nack_err === 1'b0, "slave refused a byte");
	endtask

	// Result watcher: oldest note against each result
	always @(posedge clock)
	begin
		if (wr_stb === 1'b1)
		begin
			chk(wq.size() != 0 && {reg_ptr, wr_data} === wq[0], "written word");
			if (wq.size() != 0)
				void'(wq.pop_front());
			bank[reg_ptr] = wr_data;
		end
		if (rd_valid === 1'b1)
		begin
			chk(rq.size() != 0 && rd_word === rq[0], "read word");
			if (rq.size() != 0)
				void'(rq.pop_front());
		end
		if (bus_b.s_sda_oe !== 1'b0 || stb_b !== 1'b0)
			b_seen = 1'b1;
	end

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		for (i = 0; i < 256; i++)
		begin
			bank[i] = WORD_RESET;
			bm[i] = WORD_RESET;
		end
		void'($urandom(32'h36719876));
		repeat (10) @(posedge clock);
		#1 rst = 1'b0;
		chk(reg_ptr === PTR_RESET && wr_data === WORD_RESET && cmd_ready === 1'b1, "reset values");
		for (i = 0; i < 4; i++)
		begin
			pa[i] = {i[1:0], 6'($urandom)};
			cmd(RW_WRITE, pa[i], 16'($urandom), 8'h00);
		end
		$display("test write_words done");
		// Zero words is taken as one; up to three repeated words
		for (i = 0; i < 4; i++)
			cmd(RW_READ, pa[i], 16'h0000, i[7:0]);
		$display("test read_words done");
		rd = RW_WRITE;
		vld_b = 1'b1;
		@(posedge clock);
		#1 vld_b = 1'b0;
		i = 0;
		while (done_b !== 1'b1 && i < 4000)
		begin
			@(posedge clock);
			#1 i++;
		end
		chk(i < 4000 && nack_b === 1'b1 && b_seen === 1'b0, "foreign address answered");
		$display("test wrong_address done");
		rd = RW_WRITE;
		ptr = 8'h3c;
		vld = 1'b1;
		@(posedge clock);
		#1 vld = 1'b0;
		// Master drops out in the pointer byte; the slave must discard the partial byte
		repeat (200) @(posedge clock);
		#1 cut = 1'b1;
		repeat (10) @(posedge clock);
		#1 cut = 1'b0;
		chk(reg_ptr === pa[3] && cmd_ready === 1'b1, "partial pointer byte used");
		cmd(RW_WRITE, 8'h3c, 16'($urandom), 8'h00);
		vld = 1'b1;
		@(posedge clock);
		#1 vld = 1'b0;
		// Both ends reset in mid transfer
		repeat (300) @(posedge clock);
		#1 rst = 1'b1;
		repeat (10) @(posedge clock);
		#1 rst = 1'b0;
		chk(reg_ptr === PTR_RESET && cmd_ready === 1'b1, "reset in mid transfer");
		cmd(RW_WRITE, 8'h3c, 16'($urandom), 8'h00);
		cmd(RW_READ, 8'h3c, 16'h0000, 8'h02);
		$display("test reset_abort done");
		chk(wq.size() == 0 && rq.size() == 0, "results missing");
		summarize();
	end

	initial
	begin
		#1000000;
		mismatches++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end
endmodule

`default_nettype wire
